// >>> rtl/bbs_cfg.svh
`ifndef BBS_CFG_SVH
`define BBS_CFG_SVH
`define BBS_CLK_HZ          40000000
`define BBS_BIAS_SETTLE_US  100
`define BBS_SEL_READ_US     450
`define BBS_TRANSITION_US   100
`define BBS_SS_TIMEOUT_US   4000
`define BBS_SWITCH_CURRENT_LIMIT_PERSIST_US 2000
`define BBS_US_CYCLES(us)   (((us) * (`BBS_CLK_HZ / 1000000)))
`define BBS_CNT_W           20
`define BBS_ADDR_CTRL       12'h000
`define BBS_ADDR_STATUS     12'h004
`define BBS_ADDR_FAULT      12'h008
`define BBS_CTRL_RESET      32'h0000_0000
`define BBS_CTRL_LIM_HI     0
`define BBS_CTRL_POK_OPT    1
`define BBS_FLT_THERM       0
`define BBS_FLT_SS          1
`define BBS_FLT_SWITCH_CURRENT_LIMIT        2
`define BBS_FLT_UV          3
`endif

// >>> rtl/bbs_pkg.sv
package bbs_pkg;
	typedef enum logic [2:0] {
		BBS_OFF,
		BBS_BIAS,
		BBS_SEL,
		BBS_SOFT,
		BBS_TRANS,
		BBS_RUN,
		BBS_LATCH
	} bbs_state_t;
endpackage

// >>> rtl/bbs_timer.sv
`timescale 1ns/1ps
`include "bbs_cfg.svh"
module bbs_timer #(
	parameter int W = `BBS_CNT_W
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	output logic              done
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	assign cnt_next = !run ? '0 : (cnt_reg == limit) ? cnt_reg : cnt_reg + 1'b1;
	assign done     = run && (cnt_reg == limit);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end
endmodule // bbs_timer

// >>> rtl/bbs_apb.sv
`timescale 1ns/1ps
`include "bbs_cfg.svh"
module bbs_apb (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [1:0]       ctrl,
	input  wire logic [2:0]  state_code,
	input  wire logic [3:0]  fault_cause
);
	logic [1:0]  ctrl_reg;
	logic [31:0] rdata_reg;
	wire         access = psel && penable;
	wire         hit_ctrl = paddr == `BBS_ADDR_CTRL;
	wire         hit_stat = paddr == `BBS_ADDR_STATUS;
	wire         hit_flt  = paddr == `BBS_ADDR_FAULT;
	wire         mapped   = hit_ctrl || hit_stat || hit_flt;
	wire [31:0]  rd_mux   = hit_ctrl ? {30'h0, ctrl_reg} :
	                        hit_stat ? {29'h0, state_code} :
	                        hit_flt  ? {28'h0, fault_cause} : 32'h0000_0000;
	// zero-wait slave; read data latched in setup cycle so it is stable in access
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata  = rdata_reg;
	assign ctrl    = ctrl_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg  <= 2'h0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			if (psel && !penable)
				rdata_reg <= rd_mux;
			if (access && pwrite && hit_ctrl)
				ctrl_reg <= pwdata[1:0];
		end
	end
endmodule // bbs_apb

// >>> rtl/bbs_seq.sv
`timescale 1ns/1ps
`include "bbs_cfg.svh"
module bbs_seq #(
	parameter int BIAS_CYC  = `BBS_US_CYCLES(`BBS_BIAS_SETTLE_US),
	parameter int SEL_CYC   = `BBS_US_CYCLES(`BBS_SEL_READ_US),
	parameter int TRANS_CYC = `BBS_US_CYCLES(`BBS_TRANSITION_US),
	parameter int SS_CYC    = `BBS_US_CYCLES(`BBS_SS_TIMEOUT_US),
	parameter int SWITCH_CURRENT_LIMIT_CYC  = `BBS_US_CYCLES(`BBS_SWITCH_CURRENT_LIMIT_PERSIST_US)
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        enable,
	input  wire logic        temp_above_trip,
	input  wire logic        temp_below_release,
	input  wire logic        vin_above_rising,
	input  wire logic        vin_below_falling,
	input  wire logic        out_at_target,
	input  wire logic        out_above_90pct,
	input  wire logic        out_within_10pct,
	input  wire logic        peak_current_hit,
	input  wire logic        forced_fixed_frequency_mode,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             bias_on,
	output logic             sel_read_active,
	output logic             switching_on,
	output logic             switch_off_cycle,
	output logic             soft_limit,
	output logic             limit_high_level,
	output logic             fixed_frequency,
	output logic             discharge_on,
	output logic             power_good_output_o,
	output logic             power_good_output_oe
);
	bbs_pkg::bbs_state_t state_reg;
	bbs_pkg::bbs_state_t state_next;
	logic [3:0] fault_reg;
	logic [3:0] fault_next;
	logic       en_d_reg;
	logic       disch_reg;
	logic       fixed_reg;
	logic       pg_reg;
	logic [1:0] ctrl;

	wire bias_done;
	wire sel_done;
	wire trans_done;
	wire ss_expired;
	wire switch_current_limit_expired;

	wire active      = state_reg != bbs_pkg::BBS_OFF && state_reg != bbs_pkg::BBS_LATCH;
	wire switching   = state_reg == bbs_pkg::BBS_SOFT || state_reg == bbs_pkg::BBS_TRANS ||
	                   state_reg == bbs_pkg::BBS_RUN;
	wire in_soft     = state_reg == bbs_pkg::BBS_SOFT;
	// thermal: trip at upper point, stays latched until a fresh enable edge with the die below release point
	wire f_therm     = active && temp_above_trip;
	wire f_ss        = in_soft && ss_expired && !out_above_90pct;
	wire f_switch_current_limit      = switching && switch_current_limit_expired;
	wire f_uv        = active && vin_below_falling;
	wire any_fault   = f_therm || f_ss || f_switch_current_limit || f_uv;
	wire rise_en     = enable && !en_d_reg;
	// restart: fresh enable edge, die not above trip and below release point, supply above rising threshold
	wire can_start   = rise_en && vin_above_rising && !temp_above_trip && temp_below_release;

	always_comb begin
		state_next = state_reg;
		fault_next = fault_reg;
		unique case (state_reg)
			bbs_pkg::BBS_OFF:
				if (can_start) begin
					state_next = bbs_pkg::BBS_BIAS;
					fault_next = 4'h0;
				end
			bbs_pkg::BBS_BIAS:
				if (bias_done)
					state_next = bbs_pkg::BBS_SEL;
			bbs_pkg::BBS_SEL:
				if (sel_done)
					state_next = bbs_pkg::BBS_SOFT;
			bbs_pkg::BBS_SOFT:
				if (out_at_target)
					state_next = bbs_pkg::BBS_TRANS;
			bbs_pkg::BBS_TRANS:
				if (trans_done)
					state_next = bbs_pkg::BBS_RUN;
			bbs_pkg::BBS_RUN:
				state_next = bbs_pkg::BBS_RUN;
			bbs_pkg::BBS_LATCH:
				if (can_start) begin
					state_next = bbs_pkg::BBS_BIAS;
					fault_next = 4'h0;
				end
		endcase
		if (any_fault) begin
			state_next = bbs_pkg::BBS_LATCH;
			fault_next = {f_uv, f_switch_current_limit, f_ss, f_therm};
		end else if (active && !enable) begin
			state_next = bbs_pkg::BBS_OFF;
		end
	end

	// timers all on clk and cleared whenever their state is left
	bbs_timer #(.W(`BBS_CNT_W)) u_bias (
		.clk   (clk),
		.nrst  (nrst),
		.run   (state_reg == bbs_pkg::BBS_BIAS),
		.limit (`BBS_CNT_W'(BIAS_CYC - 1)),
		.done  (bias_done)
	);
	bbs_timer #(.W(`BBS_CNT_W)) u_sel (
		.clk   (clk),
		.nrst  (nrst),
		.run   (state_reg == bbs_pkg::BBS_SEL),
		.limit (`BBS_CNT_W'(SEL_CYC - 1)),
		.done  (sel_done)
	);
	bbs_timer #(.W(`BBS_CNT_W)) u_ss (
		.clk   (clk),
		.nrst  (nrst),
		.run   (in_soft),
		.limit (`BBS_CNT_W'(SS_CYC - 1)),
		.done  (ss_expired)
	);
	bbs_timer #(.W(`BBS_CNT_W)) u_trans (
		.clk   (clk),
		.nrst  (nrst),
		.run   (state_reg == bbs_pkg::BBS_TRANS),
		.limit (`BBS_CNT_W'(TRANS_CYC - 1)),
		.done  (trans_done)
	);
	// any cycle without a limit hit restarts the window, so short overloads recover
	bbs_timer #(.W(`BBS_CNT_W)) u_switch_current_limit (
		.clk   (clk),
		.nrst  (nrst),
		.run   (switching && peak_current_hit),
		.limit (`BBS_CNT_W'(SWITCH_CURRENT_LIMIT_CYC - 1)),
		.done  (switch_current_limit_expired)
	);

	bbs_apb u_apb (
		.clk         (clk),
		.nrst        (nrst),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.ctrl        (ctrl),
		.state_code  (state_reg),
		.fault_cause (fault_reg)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= bbs_pkg::BBS_OFF;
			fault_reg <= 4'h0;
			en_d_reg  <= 1'b0;
			disch_reg <= 1'b0;
			fixed_reg <= 1'b0;
			pg_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			fault_reg <= fault_next;
			en_d_reg  <= enable;
			// one cycle after switching stops, so the switches are open first
			disch_reg <= !active && !switching_on;
			// soft start always fixed; run follows the pin with the power-good option off, skip otherwise
			fixed_reg <= in_soft || (state_next == bbs_pkg::BBS_SOFT) ||
			             (!ctrl[`BBS_CTRL_POK_OPT] && forced_fixed_frequency_mode && switching);
			pg_reg    <= ctrl[`BBS_CTRL_POK_OPT] && switching && out_within_10pct;
		end
	end

	assign bias_on          = active;
	assign sel_read_active  = state_reg == bbs_pkg::BBS_SEL;
	assign switching_on     = switching;
	assign soft_limit       = in_soft;
	assign limit_high_level = ctrl[`BBS_CTRL_LIM_HI];
	assign switch_off_cycle = switching && peak_current_hit;
	assign fixed_frequency  = fixed_reg;
	assign discharge_on     = disch_reg;
	assign power_good_output_o  = 1'b0;
	assign power_good_output_oe = pg_reg;
endmodule // bbs_seq

// >>> sim/bbs_host.sv
`timescale 1ns/1ps
module bbs_host (
	input  wire logic want_on,
	input  wire logic mode_req,
	input  wire logic pg_o,
	input  wire logic pg_oe,
	output logic      enable,
	output logic      fixed_mode,
	output logic      pg_pin
);
	// external pull-up: a released pin reads high, never the last driven level
	assign pg_pin = pg_oe ? pg_o : 1'b1;
	// requests come from the bench right after a rising edge and are held
	assign enable = want_on;
	assign fixed_mode = mode_req;
endmodule // bbs_host

// >>> sim/bbs_checker.sv
`timescale 1ns/1ps
module bbs_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic enable,
	input wire logic temp_above_trip,
	input wire logic vin_below_falling,
	input wire logic out_at_target,
	input wire logic out_within_10pct,
	input wire logic peak_current_hit,
	input wire logic bias_on,
	input wire logic sel_read_active,
	input wire logic switching_on,
	input wire logic switch_off_cycle,
	input wire logic soft_limit,
	input wire logic fixed_frequency,
	input wire logic discharge_on,
	input wire logic power_good_output_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence soft_done;
		soft_limit ##1 (!soft_limit && switching_on);
	endsequence
	restart_edge_a: assert property ($rose(bias_on) |-> $past(enable) && !$past(enable, 2))
		else $error("bias started without an enable edge");
	bias_settle_a: assert property ($rose(sel_read_active) |-> $past(bias_on, 3))
		else $error("select read began before bias settled");
	select_first_a: assert property ($rose(soft_limit) |-> $past(sel_read_active))
		else $error("soft start without select read");
	half_limit_a: assert property (soft_limit |-> switching_on)
		else $error("reduced limit while not switching");
	soft_end_a: assert property (soft_done |-> $past(out_at_target))
		else $error("soft start left before target");
	soft_fixed_a: assert property (soft_limit && $past(soft_limit) |-> fixed_frequency)
		else $error("skip operation during soft start");
	discharge_after_a: assert property ($fell(switching_on) |=> discharge_on)
		else $error("no discharge after stop");
	no_discharge_a: assert property (switching_on |-> !discharge_on)
		else $error("discharge while switching");
	enable_stop_a: assert property (!enable |=> !switching_on)
		else $error("switching with enable low");
	uv_stop_a: assert property (vin_below_falling |=> !switching_on)
		else $error("switching in undervoltage");
	therm_stop_a: assert property (temp_above_trip |=> !switching_on)
		else $error("switching when hot");
	peak_cut_a: assert property (switching_on && peak_current_hit |-> switch_off_cycle)
		else $error("peak hit did not end the cycle");
	good_follow_a: assert property (!out_within_10pct [*2] |-> !power_good_output_oe)
		else $error("power good pulled low out of band");
endmodule // bbs_checker
bind bbs_seq bbs_checker chk (.*);

// >>> sim/bbs_seq_test.sv
`timescale 1ns/1ps
module bbs_seq_test;
	localparam int BIAS = 4, SEL = 8, TRANS = 4, SS = 40, SWITCH_CURRENT_LIMIT = 20;
	logic        clk, nrst, enable, temp_above_trip, temp_below_release, vin_above_rising, vin_below_falling;
	logic        out_at_target, out_above_90pct, out_within_10pct, peak_current_hit, forced_fixed_frequency_mode;
	logic        psel, penable, pwrite, pready, pslverr, bias_on, sel_read_active, switching_on, switch_off_cycle;
	logic        soft_limit, limit_high_level, fixed_frequency, discharge_on, power_good_output_o, power_good_output_oe;
	logic        want_on, mode_req, pg_pin, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          bad_count, cmp_count, nb, ns, seed, k;
	bbs_seq #(.BIAS_CYC(BIAS), .SEL_CYC(SEL), .TRANS_CYC(TRANS), .SS_CYC(SS), .SWITCH_CURRENT_LIMIT_CYC(SWITCH_CURRENT_LIMIT)) uut (.*);
	bbs_host host (.want_on(want_on), .mode_req(mode_req), .pg_o(power_good_output_o),
		.pg_oe(power_good_output_oe), .enable(enable), .fixed_mode(forced_fixed_frequency_mode), .pg_pin(pg_pin));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// reference count of cycles spent in the bias and select startup phases
	always @(negedge clk) begin
		nb += bias_on & !sel_read_active & !switching_on;
		ns += sel_read_active;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task up(input logic fin);
		{vin_above_rising, vin_below_falling, temp_above_trip, temp_below_release} <= 4'b1001;
		{out_at_target, out_above_90pct, peak_current_hit, want_on} <= 4'b0000;
		mode_req <= 1'($random(seed));
		repeat (3) @(posedge clk);
		{nb, ns} = 0;
		want_on <= 1'b1;
		@(negedge clk iff soft_limit);
		chk("bias time", BIAS, nb);
		chk("select time", SEL, ns);
		@(negedge clk);
		chk("fixed freq", 1, fixed_frequency);
		chk("half limit", 1, soft_limit);
		if (fin) begin
			@(posedge clk);
			{out_at_target, out_above_90pct} <= 2'b11;
			@(negedge clk iff !soft_limit);
			chk("restored", 1, switching_on);
			repeat (TRANS + 2) @(posedge clk);
			apb(0, 12'h004, 0);
			chk("run state", 5, rd);
		end
	endtask
	task end_of_test;
		$display("compares %0d errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		end_of_test;
	end
	initial begin
		seed = 32'h1b86;
		{nrst, psel, penable, pwrite, paddr, pwdata, want_on, mode_req} = 0;
		{temp_above_trip, temp_below_release, vin_above_rising, vin_below_falling} = 0;
		{out_at_target, out_above_90pct, out_within_10pct, peak_current_hit} = 0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		apb(0, 12'h000, 0);
		chk("ctrl reset", 0, rd);
		k = {$random(seed)} % 2 + 2;
		apb(1, 12'h000, k);
		apb(0, 12'h000, 0);
		chk("ctrl", k, rd);
		chk("limit level", k & 1, limit_high_level);
		apb(0, 12'h00c, 0);
		chk("unmapped", 1, er);
		up(1);
		out_within_10pct <= 1'b1;
		repeat (3) @(posedge clk);
		chk("power good", 0, pg_pin);
		peak_current_hit <= 1'b1;
		repeat (SWITCH_CURRENT_LIMIT - 4) @(posedge clk);
		peak_current_hit <= 1'b0;
		repeat (SWITCH_CURRENT_LIMIT) @(posedge clk);
		chk("short overload", 1, switching_on);
		want_on <= 1'b0;
		repeat (3) @(posedge clk);
		chk("discharge", 1, discharge_on);
		// thermal, soft-start timeout, overload, undervoltage, with enable held high
		for (k = 0; k < 4; k++) begin
			up(k != 1);
			case (k)
				0: {temp_above_trip, temp_below_release} <= 2'b10;
				2: peak_current_hit <= 1'b1;
				3: {vin_above_rising, vin_below_falling} <= 2'b01;
				default: ;
			endcase
			repeat (SS + 5) @(posedge clk);
			chk("latched", 0, switching_on);
			apb(0, 12'h008, 0);
			chk("fault", 1 << k, rd);
			apb(0, 12'h004, 0);
			chk("stays off", 6, rd);
			// an enable toggle while the cause is still present must not restart
			if (k == 0 || k == 3) begin
				want_on <= 1'b0;
				repeat (3) @(posedge clk);
				want_on <= 1'b1;
				repeat (3) @(posedge clk);
				apb(0, 12'h004, 0);
				chk("no restart", 6, rd);
			end
		end
		// pin mode only counts with the power-good option off
		apb(1, 12'h000, 0);
		up(1);
		mode_req <= 1'b1;
		repeat (2) @(posedge clk);
		chk("pin fixed", 1, fixed_frequency);
		chk("pg released", 1, pg_pin);
		chk("limit level", 0, limit_high_level);
		mode_req <= 1'b0;
		repeat (2) @(posedge clk);
		chk("pin skip", 0, fixed_frequency);
		end_of_test;
	end
endmodule // bbs_seq_test
